// File: logic/hvac_point_pkg.sv
// Constants and carriers for the status and point map
package hvac_point_pkg;
  // Modbus function codes
  localparam logic [7:0] FN_READ_COILS    = 8'h01;
  localparam logic [7:0] FN_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FN_READ_HOLDING  = 8'h03;
  localparam logic [7:0] FN_READ_INPUTS   = 8'h04;
  localparam logic [7:0] FN_WRITE_SINGLE  = 8'h06;
  // Holding register addresses
  localparam logic [15:0] ADDR_START_STOP    = 16'hFC80;
  localparam logic [15:0] ADDR_STATE_FIRST   = 16'hFC90;
  localparam logic [15:0] ADDR_STATE_SECOND  = 16'hFC91;
  localparam logic [15:0] ADDR_ALARM_HIGH    = 16'hFC92;
  localparam logic [15:0] ADDR_ALARM_LOW     = 16'hFC93;
  // Start/stop command words
  localparam logic [15:0] CMD_START = 16'h00AA;
  localparam logic [15:0] CMD_STOP  = 16'h0055;
  // Device state field
  localparam int unsigned STATE_LSB = 8;
  localparam logic [2:0] DEV_STOP_OPERATOR = 3'h0;
  localparam logic [2:0] DEV_STOP_ECONOMY  = 3'h1;
  localparam logic [2:0] DEV_STOP_SCHEDULE = 3'h2;
  localparam logic [2:0] DEV_RUNNING       = 3'h5;
  localparam logic RUN_RESET = 1'b0;
  // First state register bits
  localparam int unsigned BIT_STOP_DELAY   = 7;
  localparam int unsigned BIT_PREHEAT      = 13;
  localparam int unsigned BIT_DEFROST      = 15;
  // Second state register bits
  localparam int unsigned BIT_MAIN_HEAT    = 0;
  localparam int unsigned BIT_COOLING      = 2;
  localparam int unsigned BIT_EXHAUST_HEAT = 3;
  localparam int unsigned BIT_EXCHANGER    = 7;
  localparam int unsigned BIT_BYPASS       = 8;
  localparam int unsigned BIT_GROUND       = 9;
  localparam int unsigned BIT_INLET_FAN    = 10;
  localparam int unsigned BIT_EXTRACT_FAN  = 11;
  // Alarm bits
  localparam int unsigned BIT_SENSOR_BREAK = 3;
  localparam int unsigned BIT_WATER_FROST  = 0;
  localparam int unsigned BIT_INLET_PRESS  = 2;
  localparam int unsigned BIT_HIGH_TEMP    = 5;
  localparam int unsigned BIT_EXCH_FREEZE  = 6;
  localparam int unsigned BIT_FILTER_PRESS = 9;
  // Input register segments
  localparam logic [7:0] SEG_RESISTIVE = 8'h00;
  localparam logic [7:0] SEG_ANALOG    = 8'h01;
  localparam int unsigned N_RES = 4;
  localparam int unsigned N_ANA = 4;
  // Coil and discrete input addresses
  localparam logic [15:0] COIL_BYPASS  = 16'h0002;
  localparam logic [15:0] COIL_GROUND  = 16'h0003;
  localparam logic [15:0] COIL_PUMP    = 16'h0006;
  localparam logic [15:0] COIL_COMPR   = 16'h0007;
  localparam logic [15:0] DIN_OVERTEMP = 16'h0000;
  localparam logic [15:0] DIN_FROST    = 16'h0001;
  localparam logic [15:0] DIN_USER_ONE = 16'h0002;
  localparam logic [15:0] DIN_USER_TWO = 16'h0003;
  localparam logic [15:0] DIN_START    = 16'h0004;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] wdata;
  } point_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] rdata;
  } point_rsp_t;

  typedef struct packed {
    logic stop_delay;
    logic preheat;
    logic defrost;
    logic main_heat;
    logic cooling;
    logic exhaust_heat;
    logic exchanger;
    logic bypass;
    logic ground_exchanger_active;
    logic inlet_fan;
    logic extract_fan;
    logic economy_stop;
    logic schedule_stop;
  } process_t;

  typedef struct packed {
    logic sensor_break_flag;
    logic water_coil_frost_flag;
    logic inlet_fan_pressure_flag;
    logic high_temperature_flag;
    logic exchanger_freezing_flag;
    logic filter_pressure_flag;
  } alarm_t;

  typedef struct packed {
    logic bypass_drive_output;
    logic ground_exchanger_output;
    logic heating_pump_output;
    logic cooling_compressor_output;
  } coil_t;

  typedef struct packed {
    logic heater_overtemp_input;
    logic frost_alarm_input;
    logic user_function_one_input;
    logic user_function_two_input;
    logic start_stop_input;
  } din_t;
endpackage

// File: logic/hvac_status_point_map.sv
// Modbus-visible status registers and point map of the air handler
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Bit 7 of the first state register shows the stop delay, and bit 6 always reads zero.
// - Bits 8 to 10 of the first state register hold the device state 0, 1, 2 or 5.
// - Bit 13 shows preheater heating control and bit 15 shows exchanger defrost.
// - The second state register shows the eight listed processes at their bit places.
// - The high alarm register shows only sensor break at bit 3.
// - The low alarm register shows only bits 0, 2, 5, 6 and 9.
// - Function 04 reads input registers with segment in the high byte and index low.
// - Function 01 reads coils 2, 3, 6 and 7 as the four drive outputs.
// - Function 02 reads discrete inputs 0 to 4 as the five digital inputs.
// - Writing 0x00AA to start/stop starts, 0x0055 stops, and a read returns the state.
module hvac_status_point_map (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire hvac_point_pkg::point_req_t req_i,
  output var hvac_point_pkg::point_rsp_t rsp_o,
  input  wire hvac_point_pkg::process_t  proc_i,
  input  wire hvac_point_pkg::alarm_t    alarm_i,
  input  wire hvac_point_pkg::coil_t     coil_i,
  input  wire hvac_point_pkg::din_t      din_pin_i,
  input  wire logic [16*hvac_point_pkg::N_RES-1:0] res_val_i,
  input  wire logic [16*hvac_point_pkg::N_ANA-1:0] ana_val_i,
  output logic                           run_o
);
  // Pins come from outside the clock domain
  hvac_point_pkg::din_t din_m_q;
  hvac_point_pkg::din_t din_s_q;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      din_m_q <= din_pin_i;
      din_s_q <= din_m_q;
    end
  end

  logic run_q;
  logic run_d;
  hvac_point_pkg::point_rsp_t rsp_q;
  hvac_point_pkg::point_rsp_t rsp_d;
  logic [2:0]  dev_state;
  logic [15:0] state_first;
  logic [15:0] state_second;
  logic [15:0] alarm_high;
  logic [15:0] alarm_low;

  always_comb begin
    // Stopped causes take priority by cause: schedule, then economy, else operator
    if (run_q) begin
      dev_state = hvac_point_pkg::DEV_RUNNING;
    end else if (proc_i.schedule_stop) begin
      dev_state = hvac_point_pkg::DEV_STOP_SCHEDULE;
    end else if (proc_i.economy_stop) begin
      dev_state = hvac_point_pkg::DEV_STOP_ECONOMY;
    end else begin
      dev_state = hvac_point_pkg::DEV_STOP_OPERATOR;
    end
    state_first = 16'h0000;
    state_first[hvac_point_pkg::BIT_STOP_DELAY] = proc_i.stop_delay;
    state_first[hvac_point_pkg::STATE_LSB +: 3] = dev_state;
    state_first[hvac_point_pkg::BIT_PREHEAT] = proc_i.preheat;
    state_first[hvac_point_pkg::BIT_DEFROST] = proc_i.defrost;
    state_second = 16'h0000;
    state_second[hvac_point_pkg::BIT_MAIN_HEAT] = proc_i.main_heat;
    state_second[hvac_point_pkg::BIT_COOLING] = proc_i.cooling;
    state_second[hvac_point_pkg::BIT_EXHAUST_HEAT] = proc_i.exhaust_heat;
    state_second[hvac_point_pkg::BIT_EXCHANGER] = proc_i.exchanger;
    state_second[hvac_point_pkg::BIT_BYPASS] = proc_i.bypass;
    state_second[hvac_point_pkg::BIT_GROUND] = proc_i.ground_exchanger_active;
    state_second[hvac_point_pkg::BIT_INLET_FAN] = proc_i.inlet_fan;
    state_second[hvac_point_pkg::BIT_EXTRACT_FAN] = proc_i.extract_fan;
    alarm_high = 16'h0000;
    alarm_high[hvac_point_pkg::BIT_SENSOR_BREAK] = alarm_i.sensor_break_flag;
    alarm_low = 16'h0000;
    alarm_low[hvac_point_pkg::BIT_WATER_FROST] = alarm_i.water_coil_frost_flag;
    alarm_low[hvac_point_pkg::BIT_INLET_PRESS] = alarm_i.inlet_fan_pressure_flag;
    alarm_low[hvac_point_pkg::BIT_HIGH_TEMP] = alarm_i.high_temperature_flag;
    alarm_low[hvac_point_pkg::BIT_EXCH_FREEZE] = alarm_i.exchanger_freezing_flag;
    alarm_low[hvac_point_pkg::BIT_FILTER_PRESS] = alarm_i.filter_pressure_flag;
  end

  always_comb begin
    run_d = run_q;
    rsp_d = '0;
    if (req_i.valid) begin
      rsp_d.valid = 1'b1;
      case (req_i.func)
        hvac_point_pkg::FN_READ_HOLDING: begin
          case (req_i.addr)
            hvac_point_pkg::ADDR_START_STOP: rsp_d.rdata = {13'h0000, dev_state};
            hvac_point_pkg::ADDR_STATE_FIRST: rsp_d.rdata = state_first;
            hvac_point_pkg::ADDR_STATE_SECOND: rsp_d.rdata = state_second;
            hvac_point_pkg::ADDR_ALARM_HIGH: rsp_d.rdata = alarm_high;
            hvac_point_pkg::ADDR_ALARM_LOW: rsp_d.rdata = alarm_low;
            default: rsp_d.error = 1'b1;
          endcase
        end
        hvac_point_pkg::FN_WRITE_SINGLE: begin
          // Unknown command words are refused but leave run state alone
          if (req_i.addr == hvac_point_pkg::ADDR_START_STOP) begin
            if (req_i.wdata == hvac_point_pkg::CMD_START) begin
              run_d = 1'b1;
            end else if (req_i.wdata == hvac_point_pkg::CMD_STOP) begin
              run_d = 1'b0;
            end else begin
              rsp_d.error = 1'b1;
            end
          end else begin
            rsp_d.error = 1'b1;
          end
        end
        hvac_point_pkg::FN_READ_INPUTS: begin
          if (req_i.addr[15:8] == hvac_point_pkg::SEG_RESISTIVE &&
              req_i.addr[7:0] < 8'(hvac_point_pkg::N_RES)) begin
            rsp_d.rdata = res_val_i[req_i.addr[1:0]*16 +: 16];
          end else if (req_i.addr[15:8] == hvac_point_pkg::SEG_ANALOG &&
                       req_i.addr[7:0] < 8'(hvac_point_pkg::N_ANA)) begin
            rsp_d.rdata = ana_val_i[req_i.addr[1:0]*16 +: 16];
          end else begin
            rsp_d.error = 1'b1;
          end
        end
        hvac_point_pkg::FN_READ_COILS: begin
          case (req_i.addr)
            hvac_point_pkg::COIL_BYPASS: begin
              rsp_d.rdata[0] = coil_i.bypass_drive_output;
            end
            hvac_point_pkg::COIL_GROUND: begin
              rsp_d.rdata[0] = coil_i.ground_exchanger_output;
            end
            hvac_point_pkg::COIL_PUMP: begin
              rsp_d.rdata[0] = coil_i.heating_pump_output;
            end
            hvac_point_pkg::COIL_COMPR: begin
              rsp_d.rdata[0] = coil_i.cooling_compressor_output;
            end
            default: rsp_d.error = 1'b1;
          endcase
        end
        hvac_point_pkg::FN_READ_DISCRETE: begin
          case (req_i.addr)
            hvac_point_pkg::DIN_OVERTEMP: begin
              rsp_d.rdata[0] = din_s_q.heater_overtemp_input;
            end
            hvac_point_pkg::DIN_FROST: begin
              rsp_d.rdata[0] = din_s_q.frost_alarm_input;
            end
            hvac_point_pkg::DIN_USER_ONE: begin
              rsp_d.rdata[0] = din_s_q.user_function_one_input;
            end
            hvac_point_pkg::DIN_USER_TWO: begin
              rsp_d.rdata[0] = din_s_q.user_function_two_input;
            end
            hvac_point_pkg::DIN_START: begin
              rsp_d.rdata[0] = din_s_q.start_stop_input;
            end
            default: rsp_d.error = 1'b1;
          endcase
        end
        default: rsp_d.error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= hvac_point_pkg::RUN_RESET;
      rsp_q <= '0;
    end else begin
      run_q <= run_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp_o = rsp_q;
  assign run_o = run_q;

  sequence s_start_cmd;
    req_i.valid && req_i.func == hvac_point_pkg::FN_WRITE_SINGLE &&
      req_i.addr == hvac_point_pkg::ADDR_START_STOP && req_i.wdata == hvac_point_pkg::CMD_START;
  endsequence
  sequence s_stop_cmd;
    req_i.valid && req_i.func == hvac_point_pkg::FN_WRITE_SINGLE &&
      req_i.addr == hvac_point_pkg::ADDR_START_STOP && req_i.wdata == hvac_point_pkg::CMD_STOP;
  endsequence

  property p_start;
    @(posedge sys_clk_i) disable iff (!rst_b_i) s_start_cmd |=> run_o;
  endproperty
  a_start: assert property (p_start) else $error("Start word did not start");
  property p_stop;
    @(posedge sys_clk_i) disable iff (!rst_b_i) s_stop_cmd |=> !run_o;
  endproperty
  a_stop: assert property (p_stop) else $error("Stop word did not stop");
  property p_run_state;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_HOLDING &&
      req_i.addr == hvac_point_pkg::ADDR_STATE_FIRST && run_o
      |=> rsp_o.rdata[10:8] == 3'h5 && !rsp_o.rdata[6];
  endproperty
  a_run_state: assert property (p_run_state) else $error("Running state wrong");
  property p_delay_bit;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_HOLDING &&
      req_i.addr == hvac_point_pkg::ADDR_STATE_FIRST
      |=> rsp_o.rdata[7] == $past(proc_i.stop_delay) && rsp_o.rdata[5:0] == 6'h00;
  endproperty
  a_delay_bit: assert property (p_delay_bit) else $error("Stop delay bit wrong");
  property p_first_bits;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_HOLDING &&
      req_i.addr == hvac_point_pkg::ADDR_STATE_FIRST
      |=> rsp_o.rdata[13] == $past(proc_i.preheat) && rsp_o.rdata[15] == $past(proc_i.defrost);
  endproperty
  a_first_bits: assert property (p_first_bits) else $error("Preheat/defrost bit wrong");
  property p_second;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_HOLDING &&
      req_i.addr == hvac_point_pkg::ADDR_STATE_SECOND
      |=> rsp_o.rdata[9] == $past(proc_i.ground_exchanger_active) &&
          rsp_o.rdata[15:12] == 4'h0 && rsp_o.rdata[0] == $past(proc_i.main_heat);
  endproperty
  a_second: assert property (p_second) else $error("Second state register wrong");
  property p_alarm_high;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_HOLDING &&
      req_i.addr == hvac_point_pkg::ADDR_ALARM_HIGH
      |=> rsp_o.rdata == {12'h000, $past(alarm_i.sensor_break_flag), 3'h0};
  endproperty
  a_alarm_high: assert property (p_alarm_high) else $error("High alarm word wrong");
  property p_alarm_low;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_HOLDING &&
      req_i.addr == hvac_point_pkg::ADDR_ALARM_LOW
      |=> (rsp_o.rdata & 16'hFD9A) == 16'h0000 &&
          rsp_o.rdata[9] == $past(alarm_i.filter_pressure_flag);
  endproperty
  a_alarm_low: assert property (p_alarm_low) else $error("Low alarm word wrong");
  property p_status_write;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_WRITE_SINGLE &&
      req_i.addr != hvac_point_pkg::ADDR_START_STOP |=> rsp_o.error && $stable(run_o);
  endproperty
  a_status_write: assert property (p_status_write) else $error("Status write acted");
  property p_coil;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_COILS &&
      req_i.addr == hvac_point_pkg::COIL_COMPR
      |=> rsp_o.rdata == {15'h0000, $past(coil_i.cooling_compressor_output)};
  endproperty
  a_coil: assert property (p_coil) else $error("Compressor coil wrong");
  property p_din;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_DISCRETE &&
      req_i.addr == hvac_point_pkg::DIN_START
      |=> rsp_o.rdata == {15'h0000, $past(din_s_q.start_stop_input)};
  endproperty
  a_din: assert property (p_din) else $error("Start/stop input wrong");
  property p_input_reg;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      req_i.valid && req_i.func == hvac_point_pkg::FN_READ_INPUTS && req_i.addr == 16'h0100
      |=> rsp_o.rdata == $past(ana_val_i[15:0]) && !rsp_o.error;
  endproperty
  a_input_reg: assert property (p_input_reg) else $error("First analog input wrong");
endmodule

`default_nettype wire

// File: tb/hvac_master_model.sv
// Behavioural bus master standing in for the building controller
`timescale 1ns/10ps
`default_nettype none
module hvac_master_model (
  input  wire logic                       sys_clk_i,
  input  wire hvac_point_pkg::point_rsp_t rsp_i,
  output var  hvac_point_pkg::point_req_t req_o
);
  initial begin
    req_o = '0;
  end

  // One request per call; released fields show inverted data, never the stale word
  task automatic xfer(input logic [7:0] func, input logic [15:0] addr,
                      input logic [15:0] wdata, output hvac_point_pkg::point_rsp_t rsp);
    @(posedge sys_clk_i);
    req_o <= {1'b1, func, addr, wdata};
    @(posedge sys_clk_i);
    req_o <= {1'b0, ~func, ~addr, ~wdata};
    @(posedge sys_clk_i);
    rsp = rsp_i;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the status and point map
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                       sys_clk_i = 1'b0;
  logic                       rst_b_i;
  hvac_point_pkg::point_req_t req;
  hvac_point_pkg::point_rsp_t rsp;
  hvac_point_pkg::process_t   proc;
  hvac_point_pkg::alarm_t     alarm;
  hvac_point_pkg::coil_t      coil;
  hvac_point_pkg::din_t       din;
  logic [63:0]                res_val;
  logic [63:0]                ana_val;
  logic                       run;
  int                         error_cnt = 0;
  int                         compares = 0;
  int                         cycles = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  hvac_status_point_map dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_i(req),
    .rsp_o(rsp), .proc_i(proc), .alarm_i(alarm), .coil_i(coil), .din_pin_i(din),
    .res_val_i(res_val), .ana_val_i(ana_val), .run_o(run));
  hvac_master_model u_master (.sys_clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req));

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Run is under a thousand cycles; the ceiling leaves wide margin
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write data echo is not defined, so only refused writes have their data checked
  task automatic xf(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
                    input logic err, input logic [15:0] exp);
    hvac_point_pkg::point_rsp_t r;
    u_master.xfer(f, a, w, r);
    chk({14'h0, r.valid, r.error}, {14'h0, 1'b1, err});
    if (err || f != hvac_point_pkg::FN_WRITE_SINGLE) chk(r.rdata, err ? 16'h0 : exp);
  endtask

  task automatic rh(input logic [15:0] a, input logic [15:0] exp);
    xf(hvac_point_pkg::FN_READ_HOLDING, a, 16'h0, 1'b0, exp);
  endtask

  function automatic logic [15:0] exp_first(hvac_point_pkg::process_t p, logic r);
    logic [2:0] st;
    st = r ? 3'h5 : p.schedule_stop ? 3'h2 : p.economy_stop ? 3'h1 : 3'h0;
    return {p.defrost, 1'b0, p.preheat, 2'h0, st, p.stop_delay, 7'h0};
  endfunction

  function automatic logic [15:0] exp_second(hvac_point_pkg::process_t p);
    return {4'h0, p.extract_fan, p.inlet_fan, p.ground_exchanger_active, p.bypass,
            p.exchanger, 3'h0, p.exhaust_heat, p.cooling, 1'b0, p.main_heat};
  endfunction

  task automatic t_state();
    hvac_point_pkg::process_t p;
    for (int i = 0; i <= 13; i++) begin
      // Expectation from the local copy; the driven input updates only after this step
      p = (i == 13) ? 13'h1FFF : 13'h0001 << i;
      proc <= p;
      rh(hvac_point_pkg::ADDR_STATE_FIRST, exp_first(p, 1'b0));
      rh(hvac_point_pkg::ADDR_STATE_SECOND, exp_second(p));
    end
    proc <= '0;
  endtask

  task automatic t_alarm();
    hvac_point_pkg::alarm_t a;
    for (int i = 0; i <= 6; i++) begin
      a = (i == 6) ? 6'h3F : 6'h01 << i;
      alarm <= a;
      rh(hvac_point_pkg::ADDR_ALARM_HIGH, {12'h0, a.sensor_break_flag, 3'h0});
      rh(hvac_point_pkg::ADDR_ALARM_LOW, {6'h0, a.filter_pressure_flag, 2'h0,
         a.exchanger_freezing_flag, a.high_temperature_flag, 2'h0,
         a.inlet_fan_pressure_flag, 1'b0, a.water_coil_frost_flag});
    end
  endtask

  task automatic t_run();
    xf(hvac_point_pkg::FN_WRITE_SINGLE, hvac_point_pkg::ADDR_START_STOP,
       hvac_point_pkg::CMD_START, 1'b0, 16'h0);
    chk({15'h0, run}, 16'h0001);
    rh(hvac_point_pkg::ADDR_START_STOP, 16'h0005);
    rh(hvac_point_pkg::ADDR_STATE_FIRST, exp_first(proc, 1'b1));
    // A bad command word must leave the unit running
    xf(hvac_point_pkg::FN_WRITE_SINGLE, hvac_point_pkg::ADDR_START_STOP,
       16'h1234, 1'b1, 16'h0);
    xf(hvac_point_pkg::FN_WRITE_SINGLE, hvac_point_pkg::ADDR_STATE_FIRST,
       hvac_point_pkg::CMD_STOP, 1'b1, 16'h0);
    chk({15'h0, run}, 16'h0001);
    xf(hvac_point_pkg::FN_WRITE_SINGLE, hvac_point_pkg::ADDR_START_STOP,
       hvac_point_pkg::CMD_STOP, 1'b0, 16'h0);
    chk({15'h0, run}, 16'h0000);
    rh(hvac_point_pkg::ADDR_START_STOP, 16'h0000);
  endtask

  task automatic t_inputs();
    res_val <= 64'hC003_C002_C001_C000;
    ana_val <= 64'hC013_C012_C011_C010;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 4; i++)
        xf(hvac_point_pkg::FN_READ_INPUTS, {8'(s), 8'(i)}, 16'h0, 1'b0,
           {8'hC0, 4'(s), 4'(i)});
    xf(hvac_point_pkg::FN_READ_INPUTS, 16'h0004, 16'h0, 1'b1, 16'h0);
    xf(hvac_point_pkg::FN_READ_INPUTS, 16'h0200, 16'h0, 1'b1, 16'h0);
  endtask

  task automatic t_coil();
    logic [63:0] ca;
    logic [3:0]  c;
    ca = {hvac_point_pkg::COIL_BYPASS, hvac_point_pkg::COIL_GROUND,
          hvac_point_pkg::COIL_PUMP, hvac_point_pkg::COIL_COMPR};
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      coil <= c;
      for (int j = 0; j < 4; j++)
        xf(hvac_point_pkg::FN_READ_COILS, ca[48-16*j +: 16], 16'h0, 1'b0,
           {15'h0, c[3-j]});
    end
    xf(hvac_point_pkg::FN_READ_COILS, 16'h0008, 16'h0, 1'b1, 16'h0);
  endtask

  task automatic t_din();
    for (int k = 0; k < 32; k++) begin
      din <= 5'(k);
      // Pins pass a two-stage synchroniser before they are seen
      repeat (2) @(posedge sys_clk_i);
      for (int j = 0; j < 5; j++)
        xf(hvac_point_pkg::FN_READ_DISCRETE, 16'(j), 16'h0, 1'b0, {15'h0, din[4-j]});
    end
    xf(8'h10, 16'h0000, 16'h0, 1'b1, 16'h0);
  endtask

  // Reset while running must return the unit to stopped by operator
  task automatic t_reset();
    xf(hvac_point_pkg::FN_WRITE_SINGLE, hvac_point_pkg::ADDR_START_STOP,
       hvac_point_pkg::CMD_START, 1'b0, 16'h0);
    chk({15'h0, run}, 16'h0001);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk({15'h0, run}, 16'h0000);
    chk({14'h0, rsp.valid, rsp.error}, 16'h0000);
    rst_b_i <= 1'b1;
    rh(hvac_point_pkg::ADDR_START_STOP, 16'h0000);
  endtask

  initial begin
    rst_b_i = 1'b0;
    proc = '0;
    alarm = '0;
    coil = '0;
    din = '0;
    res_val = '0;
    ana_val = '0;
    repeat (12) @(posedge sys_clk_i);
    chk({15'h0, run}, 16'h0000);
    rst_b_i <= 1'b1;
    rh(hvac_point_pkg::ADDR_START_STOP, 16'h0000);
    t_state();
    t_alarm();
    t_run();
    t_inputs();
    t_coil();
    t_din();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
